// [rtl/snp_cfg.svh]
// constants of the second network parameter bank
// assumes inclusion by the bank module and its bench
`ifndef SNP_CFG_SVH
`define SNP_CFG_SVH

// register indices, byte address is four times the index
`define SNP_IDX_CHAN_INT    6'h10
`define SNP_IDX_CHAN_FRAC   6'h11
`define SNP_IDX_NET_ID      6'h13
`define SNP_IDX_SHORT       6'h15
`define SNP_IDX_LONG        6'h17
`define SNP_IDX_LAST_BYTE   6'h1E
`define SNP_IDX_CTRL        6'h1F
`define SNP_IDX_STATUS      6'h20

// field positions
`define SNP_INT_MSB         4
`define SNP_CTRL_ACTIVE     0
`define SNP_CTRL_COORD      2

// reset values
`define SNP_RST_INT         8'h00
`define SNP_RST_BYTE        8'hFF
`define SNP_RST_CTRL        8'h00

// synthesizer relation: (int + 64) * 65536 + frac units of ref/65536
`define SNP_INT_OFFSET      7'h40
`define SNP_REF_MHZ         32
`define SNP_FRAC_STEPS      65536

`endif

// [rtl/snp_pkg.sv]
// types of the second network parameter bank
// assumes the frame parser codes frame type and addressing as below
package snp_pkg;

    // received frame type
    typedef enum logic [1:0] {
        SNP_FT_BEACON = 2'h0,
        SNP_FT_DATA   = 2'h1,
        SNP_FT_ACK    = 2'h2,
        SNP_FT_CMD    = 2'h3
    } snp_frame_type;

    // destination addressing mode
    typedef enum logic [1:0] {
        SNP_AM_NONE  = 2'h0,
        SNP_AM_RSVD  = 2'h1,
        SNP_AM_SHORT = 2'h2,
        SNP_AM_LONG  = 2'h3
    } snp_addr_mode_type;

endpackage

// [rtl/snp_param_bank.sv]
// second network parameter bank with APB slave and frame address match
// assumes frame parser inputs and first set inputs on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "snp_cfg.svh"

module snp_param_bank
    import snp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // first network parameter set
    input  wire logic [4:0]  first_channel_integer,
    input  wire logic [15:0] first_channel_fraction,
    input  wire logic [15:0] first_network_id,
    input  wire logic [15:0] first_short_address,
    input  wire logic [63:0] first_long_address,
    input  wire logic        first_network_coordinator_flag,
    // received frame header from the parser
    input  wire logic        frame_valid,
    input  wire logic [1:0]  frame_type,
    input  wire logic [1:0]  frame_dst_mode,
    input  wire logic [15:0] frame_dst_network_id,
    input  wire logic [15:0] frame_src_network_id,
    input  wire logic [63:0] frame_dst_address,
    // active set towards synthesizer and packet processor
    output logic             active_second,
    output logic [22:0]      channel_word,
    output logic [15:0]      active_network_id,
    output logic [15:0]      active_short_address,
    output logic [63:0]      active_long_address,
    // match verdict
    output logic             match_done,
    output logic             match_network,
    output logic             match_address,
    output logic             match_accept
);

    localparam int NBYTES = 15;

    // byte array, element 0 is the integer register
    logic [7:0]  bytes_reg [NBYTES];
    logic [7:0]  ctrl_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        done_reg;
    logic        net_ok_reg;
    logic        addr_ok_reg;
    logic        accept_reg;
    logic [22:0] channel_reg;
    logic [15:0] net_id_reg;
    logic [15:0] short_reg;
    logic [63:0] long_reg;
    logic        sel_second_reg;

    // second set assembled from the bytes
    logic [4:0]  sec_int;
    logic [15:0] sec_frac;
    logic [15:0] sec_net;
    logic [15:0] sec_short;
    logic [63:0] sec_long;

    // decode word index from the byte address
    function automatic logic [5:0] word_index(input logic [31:0] a);
        word_index = a[7:2];
    endfunction

    // true for an index inside the byte array
    function automatic logic in_bank(input logic [5:0] i);
        in_bank = (i >= `SNP_IDX_CHAN_INT) && (i <= `SNP_IDX_LAST_BYTE);
    endfunction

    // array slot of a bank index
    function automatic logic [3:0] slot(input logic [5:0] i);
        logic [5:0] d;
        d = i - `SNP_IDX_CHAN_INT;
        slot = d[3:0];
    endfunction

    // true when the upper address bits select this bank and the address is word aligned
    function automatic logic hi_ok(input logic [31:0] a);
        hi_ok = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0);
    endfunction

    logic [5:0] idx;
    logic       mapped;
    logic       wr_go;

    assign idx    = word_index(paddr);
    assign mapped = hi_ok(paddr) &&
                    (in_bank(idx) || idx == `SNP_IDX_CTRL ||
                     idx == `SNP_IDX_STATUS);
    // write lands only on the completing access edge
    assign wr_go  = psel && penable && pwrite && mapped && pstrb[0];

    // zero wait state slave, answer computed in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    // byte registers, integer bits 7:5 held at zero
    // the status index is read only, a write to it is dropped quietly
    always_ff @(posedge clk) begin
        if (rst) begin
            bytes_reg[0] <= `SNP_RST_INT;
            for (int k = 1; k < NBYTES; k++) begin
                bytes_reg[k] <= `SNP_RST_BYTE;
            end
        end else if (wr_go && in_bank(idx)) begin
            if (idx == `SNP_IDX_CHAN_INT) begin
                bytes_reg[0] <= {3'h0, pwdata[`SNP_INT_MSB:0]};
            end else begin
                bytes_reg[slot(idx)] <= pwdata[7:0];
            end
        end
    end

    // control: active network and second coordinator flag
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `SNP_RST_CTRL;
        end else if (wr_go && idx == `SNP_IDX_CTRL) begin
            ctrl_reg <= {5'h00, pwdata[`SNP_CTRL_COORD], 1'b0,
                         pwdata[`SNP_CTRL_ACTIVE]};
        end
    end

    // read data and error latched during the setup cycle
    // a write that landed at the previous access edge is already visible,
    // so back to back write then read returns the new byte
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_reg <= !mapped;
            prdata_reg  <= 32'h00000000;
            if (!pwrite && mapped) begin
                if (in_bank(idx)) begin
                    prdata_reg <= {24'h000000, bytes_reg[slot(idx)]};
                end else if (idx == `SNP_IDX_CTRL) begin
                    prdata_reg <= {24'h000000, ctrl_reg};
                end else begin
                    prdata_reg <= {28'h0000000, accept_reg,
                                   addr_ok_reg, net_ok_reg,
                                   sel_second_reg};
                end
            end
        end
    end

    // assemble second set, lowest index is least significant
    always_comb begin
        sec_int   = bytes_reg[0][`SNP_INT_MSB:0];
        sec_frac  = {bytes_reg[2], bytes_reg[1]};
        sec_net   = {bytes_reg[4], bytes_reg[3]};
        sec_short = {bytes_reg[6], bytes_reg[5]};
        sec_long  = {bytes_reg[14], bytes_reg[13],
                     bytes_reg[12], bytes_reg[11],
                     bytes_reg[10], bytes_reg[9],
                     bytes_reg[8],  bytes_reg[7]};
    end

    // channel word from integer plus offset and fraction
    function automatic logic [22:0] chan_word(input logic [4:0]  i,
                                              input logic [15:0] f);
        logic [6:0] n;
        // seven bits hold the largest integer field plus the offset
        n = {2'h0, i} + `SNP_INT_OFFSET;
        chan_word = {n, f};
    endfunction

    // active parameter set chosen by the active network bit
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_second_reg <= 1'b0;
            channel_reg    <= 23'h000000;
            net_id_reg     <= 16'hFFFF;
            short_reg      <= 16'hFFFF;
            long_reg       <= 64'hFFFFFFFFFFFFFFFF;
        end else if (ctrl_reg[`SNP_CTRL_ACTIVE]) begin
            sel_second_reg <= 1'b1;
            channel_reg    <= chan_word(sec_int, sec_frac);
            net_id_reg     <= sec_net;
            short_reg      <= sec_short;
            long_reg       <= sec_long;
        end else begin
            sel_second_reg <= 1'b0;
            channel_reg    <= chan_word(first_channel_integer,
                                        first_channel_fraction);
            net_id_reg     <= first_network_id;
            short_reg      <= first_short_address;
            long_reg       <= first_long_address;
        end
    end

    assign active_second        = sel_second_reg;
    assign channel_word         = channel_reg;
    assign active_network_id    = net_id_reg;
    assign active_short_address = short_reg;
    assign active_long_address  = long_reg;

    // coordinator flag of the selected network
    logic coord;
    assign coord = sel_second_reg ? ctrl_reg[`SNP_CTRL_COORD]
                                  : first_network_coordinator_flag;

    // network and address comparison for one frame header
    logic net_ok;
    logic addr_ok;
    logic data_or_cmd;

    assign data_or_cmd = (frame_type == SNP_FT_DATA) ||
                         (frame_type == SNP_FT_CMD);

    always_comb begin
        net_ok  = 1'b0;
        addr_ok = 1'b0;
        // ack frames that carry an address mode are judged like data;
        // frame type filtering sits upstream of this compare
        if (frame_type == SNP_FT_BEACON) begin
            net_ok  = (frame_src_network_id == net_id_reg);
            addr_ok = net_ok;
        end else begin
            case (frame_dst_mode)
                SNP_AM_NONE: begin
                    if (coord && data_or_cmd) begin
                        net_ok  = (frame_src_network_id == net_id_reg);
                        addr_ok = net_ok;
                    end
                end
                SNP_AM_SHORT: begin
                    net_ok  = (frame_dst_network_id == net_id_reg);
                    addr_ok = (frame_dst_address[15:0] == short_reg);
                end
                SNP_AM_LONG: begin
                    net_ok  = (frame_dst_network_id == net_id_reg);
                    addr_ok = (frame_dst_address == long_reg);
                end
                default: begin
                    net_ok  = 1'b0;
                    addr_ok = 1'b0;
                end
            endcase
        end
    end

    // registered verdict, one cycle after the header strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= frame_valid;
        end
    end

    // verdict bits held until the next frame
    always_ff @(posedge clk) begin
        if (rst) begin
            net_ok_reg  <= 1'b0;
            addr_ok_reg <= 1'b0;
            accept_reg  <= 1'b0;
        end else if (frame_valid) begin
            net_ok_reg  <= net_ok;
            addr_ok_reg <= addr_ok;
            accept_reg  <= net_ok && addr_ok;
        end
    end

    assign match_done    = done_reg;
    assign match_network = net_ok_reg;
    assign match_address = addr_ok_reg;
    assign match_accept  = accept_reg;

endmodule

`default_nettype wire

// [tb/snp_bank_props.sv]
// assertions on the ports of the second network parameter bank
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps
`default_nettype none
module snp_bank_props
    import snp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [4:0]  first_channel_integer,
    input wire logic [15:0] first_channel_fraction,
    input wire logic [15:0] first_network_id,
    input wire logic        first_network_coordinator_flag,
    input wire logic        frame_valid,
    input wire logic [1:0]  frame_type,
    input wire logic [1:0]  frame_dst_mode,
    input wire logic [15:0] frame_dst_network_id,
    input wire logic [15:0] frame_src_network_id,
    input wire logic [63:0] frame_dst_address,
    input wire logic        active_second,
    input wire logic [22:0] channel_word,
    input wire logic [15:0] active_network_id,
    input wire logic [15:0] active_short_address,
    input wire logic [63:0] active_long_address,
    input wire logic        match_done,
    input wire logic        match_network,
    input wire logic        match_address,
    input wire logic        match_accept
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic dst_hit, src_hit, sh_hit, lg_hit, data_cmd;
    // header fields against the set in force at the frame edge
    assign dst_hit = frame_dst_network_id == active_network_id;
    assign src_hit = frame_src_network_id == active_network_id;
    assign sh_hit = frame_dst_address[15:0] == active_short_address;
    assign lg_hit = frame_dst_address == active_long_address;
    assign data_cmd = frame_type == SNP_FT_DATA || frame_type == SNP_FT_CMD;

    done_pulse_a: assert property (frame_valid |=> match_done)
        else $error("verdict pulse missing after a frame");
    done_only_a: assert property (!frame_valid |=> !match_done)
        else $error("verdict pulse without a frame");
    accept_and_a: assert property (match_done |->
        match_accept == (match_network && match_address))
        else $error("accept differs from network and address");
    beacon_src_a: assert property (
        frame_valid && frame_type == SNP_FT_BEACON |=>
        match_network == $past(src_hit) && match_address == match_network)
        else $error("beacon not judged by source id");
    short_dst_a: assert property (
        frame_valid && data_cmd && frame_dst_mode == SNP_AM_SHORT |=>
        match_network == $past(dst_hit) && match_address == $past(sh_hit))
        else $error("short destination judged wrongly");
    long_dst_a: assert property (
        frame_valid && data_cmd && frame_dst_mode == SNP_AM_LONG |=>
        match_network == $past(dst_hit) && match_address == $past(lg_hit))
        else $error("long destination judged wrongly");
    coord_none_a: assert property (
        frame_valid && data_cmd && !active_second &&
        first_network_coordinator_flag && frame_dst_mode == SNP_AM_NONE
        |=> match_network == $past(src_hit))
        else $error("coordinator frame without destination misjudged");
    first_chan_a: assert property (
        !$past(rst) && !$past(active_second) && !active_second |->
        channel_word == {$past(first_channel_integer) + 7'h40,
                         $past(first_channel_fraction)})
        else $error("channel word does not follow the first set");
    first_id_a: assert property (
        !$past(rst) && !$past(active_second) && !active_second |->
        active_network_id == $past(first_network_id))
        else $error("network id does not follow the first set");
    cover property (match_done && match_accept && active_second);
    cover property (match_done && match_accept && !active_second);
    cover property (match_done && !match_accept);
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the second network parameter bank
// assumes the bank, its package and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import snp_pkg::*;
    localparam logic [63:0] LONG2 = 64'h5E5D5C5B5A595857;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, active_second, err;
    logic [31:0] prdata, rd;
    logic [4:0]  first_channel_integer = 5'h03;
    logic [15:0] first_channel_fraction = 16'h1357;
    logic [15:0] first_network_id = 16'h1111;
    logic [15:0] first_short_address = 16'h2222;
    logic [63:0] first_long_address = 64'h0;
    logic        first_network_coordinator_flag = 1'b1;
    logic        frame_valid = 1'b0;
    logic [1:0]  frame_type = 2'h0, frame_dst_mode = 2'h0;
    logic [15:0] frame_dst_network_id = 16'h0, frame_src_network_id = 16'h0;
    logic [63:0] frame_dst_address = 64'h0;
    logic [22:0] channel_word;
    logic [15:0] active_network_id, active_short_address;
    logic [63:0] active_long_address;
    logic        match_done, match_network, match_address, match_accept;
    int          error_cnt = 0, num_checks = 0;

    snp_param_bank uut (.*);

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bounded wait for a flag sampled high at a rising edge
    task automatic wait_hi(ref logic f);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (f !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            give_verdict();
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [5:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        wait_hi(pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk("prdata", {32'h0, rd}, {56'h0, e});
    endtask

    // one frame header, then the accept verdict
    task automatic frm(input logic [1:0] t, m, input logic [15:0] di, si,
                       input logic [63:0] a, input logic e);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_type <= t;
        frame_dst_mode <= m;
        frame_dst_network_id <= di;
        frame_src_network_id <= si;
        frame_dst_address <= a;
        @(posedge clk);
        frame_valid <= 1'b0;
        wait_hi(match_done);
        chk("match_accept", {63'h0, match_accept}, {63'h0, e});
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(6'h10, 8'h00);
        for (int i = 6'h11; i <= 6'h1E; i++) begin
            rdchk(i[5:0], 8'hFF);
        end
        apb(1'b1, 6'h10, 8'hFF);
        rdchk(6'h10, 8'h1F);
        apb(1'b1, 6'h30, 8'h55);
        chk("pslverr", {63'h0, err}, 64'h1);
        // second set integer byte 0x05, the other bytes index plus 0x40, then select it
        apb(1'b1, 6'h10, 8'h05);
        for (int i = 6'h11; i <= 6'h1E; i++) begin
            apb(1'b1, i[5:0], 8'h40 + 8'(i));
        end
        apb(1'b1, 6'h1F, 8'h05);
        repeat (2) @(posedge clk);
        chk("channel_word", 64'(channel_word), 64'h455251);
        chk("network_id", 64'(active_network_id), 64'h5453);
        chk("short", 64'(active_short_address), 64'h5655);
        chk("long", active_long_address, LONG2);
        chk("active_second", {63'h0, active_second}, 64'h1);
        rdchk(6'h1F, 8'h05);
        // beacon, data short, command long, no destination, ack
        frm(2'h0, 2'h0, 16'h0, 16'h5453, 64'h0, 1'b1);
        frm(2'h0, 2'h0, 16'h5453, 16'h0, 64'h0, 1'b0);
        frm(2'h1, 2'h2, 16'h5453, 16'h0, 64'h5655, 1'b1);
        frm(2'h1, 2'h2, 16'h5453, 16'h0, 64'h5656, 1'b0);
        frm(2'h3, 2'h3, 16'h5453, 16'h0, LONG2, 1'b1);
        frm(2'h3, 2'h3, 16'h5454, 16'h0, LONG2, 1'b0);
        frm(2'h1, 2'h0, 16'h0, 16'h5453, 64'h0, 1'b1);
        frm(2'h2, 2'h2, 16'h5453, 16'h5453, 64'h5655, 1'b1);
        rdchk(6'h20, 8'h0F);
        frm(2'h2, 2'h0, 16'h0, 16'h5453, 64'h0, 1'b0);
        // back to the first set with new first values
        apb(1'b1, 6'h1F, 8'h00);
        first_network_id <= 16'h2468;
        first_channel_integer <= 5'h1F;
        repeat (2) @(posedge clk);
        chk("channel_word", 64'(channel_word), 64'h5F1357);
        chk("network_id", 64'(active_network_id), 64'h2468);
        chk("active_second", {63'h0, active_second}, 64'h0);
        chk("short", 64'(active_short_address), 64'h2222);
        chk("long", active_long_address, 64'h0);
        // second network unused again: restore its frequency words
        apb(1'b1, 6'h10, 8'h00);
        apb(1'b1, 6'h11, 8'hFF);
        apb(1'b1, 6'h12, 8'hFF);
        rdchk(6'h10, 8'h00);
        rdchk(6'h12, 8'hFF);
        // byte lane 0 disabled: the write is dropped
        pstrb <= 4'hE;
        apb(1'b1, 6'h13, 8'h00);
        pstrb <= 4'hF;
        rdchk(6'h13, 8'h53);
        frm(2'h1, 2'h0, 16'h0, 16'h2468, 64'h0, 1'b1);
        frm(2'h1, 2'h0, 16'h0, 16'h5453, 64'h0, 1'b0);
        // not a coordinator, then a reserved destination mode
        first_network_coordinator_flag <= 1'b0;
        frm(2'h1, 2'h0, 16'h0, 16'h2468, 64'h0, 1'b0);
        frm(2'h1, 2'h1, 16'h2468, 16'h0, 64'h2222, 1'b0);
        give_verdict();
    end
endmodule

bind snp_param_bank snp_bank_props chk_i (.*);
`default_nettype wire
